// ---- verilog/vms_voltage_monitor.sv ----
`timescale 1ns/1ps
// How it works
// - An option-byte bit picks whether monitor 0 reset is armed at boot.
// - Option byte lives at FFFFh; value 09Fh keeps monitor 0 reset armed.
// - Writing 1 to monitor 0 reset enable arms the monitor 0 reset.
// - Shared enable bit gates both monitor 1 and monitor 2.
// - Two-bit field selects the filter sampling clock when filtering.
// - Timing bit picks rising or falling crossing when filter bypassed.
// - Filter disable bit: 0 filters, 1 bypasses.
// - Mode bit: 0 raises interrupt, 1 raises reset.
// - Monitor 1 enable bit finally enables interrupt or reset.
// - Crossings before enable raise nothing but still set the flag.
module vms_voltage_monitor #(
    parameter logic [7:0] OPTION_BYTE = vms_pkg::OPTION_BYTE_DEF
) (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        det0_below_i,
    input  wire logic        det1_above_i,
    output logic             mon0_reset_o,
    output logic             mon1_reset_o,
    output logic             mon12_en_o,
    output logic [3:0]       mon1_threshold_o,
    output logic             det0_en_o,
    output logic             det1_en_o,
    output logic             lowspeed_osc_en_o,
    output logic             irq_o
);
    logic        wr_en;
    logic        rd_en;
    logic        boot_done;

    // Register images
    logic [7:0]  detector_control_reg;
    logic [7:0]  mon0_control_reg;
    logic [7:0]  monitor_enable_reg;
    logic [7:0]  mon1_threshold_reg;
    logic [7:0]  mon1_control_reg;
    logic [7:0]  clock_mode_reg_one;
    logic [vms_pkg::IRQ_W-1:0] irq_status;
    logic [vms_pkg::IRQ_W-1:0] irq_mask;

    // Monitor 1 control fields
    logic        mon1_en;
    logic        mon1_filter_disable;
    logic        mon1_mode_sel;
    logic        mon1_request_timing;
    logic [1:0]  mon1_filter_clk_sel;
    logic        mon1_crossing_flag;

    // Oscillator, sampling and filter
    logic [7:0]  losc_cnt;
    logic        losc_tick;
    logic [2:0]  fdiv_cnt;
    logic        samp_tick;
    logic [vms_pkg::FILT_STAGES-1:0] filt_sh;
    logic        filt_level;

    // Edge detection
    logic        det_level;
    logic        det_prev;
    logic        crossing;
    logic        next_filt_level;
    logic [7:0]  next_mon1_ctrl;
    logic [vms_pkg::IRQ_W-1:0] next_irq_status;

    assign wr_en     = psel_i & penable_i & pwrite_i;
    assign rd_en     = psel_i & penable_i & ~pwrite_i;
    // Every access completes in its first access cycle
    assign pready_o  = 1'b1;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] r);
        addr_hit = (a == r);
    endfunction

    // Unmapped addresses answer with an error in the access phase
    always_comb begin
        unique case (paddr_i)
            vms_pkg::ADDR_OPTION,
            vms_pkg::ADDR_DETCTRL,
            vms_pkg::ADDR_MON0CTRL,
            vms_pkg::ADDR_MONEN,
            vms_pkg::ADDR_THRESH,
            vms_pkg::ADDR_MON1CTRL,
            vms_pkg::ADDR_CLKMODE,
            vms_pkg::ADDR_IRQSTAT,
            vms_pkg::ADDR_IRQMASK: pslverr_o = 1'b0;
            default: pslverr_o = psel_i & penable_i;
        endcase
    end

    assign mon1_en             = mon1_control_reg[vms_pkg::M1_EN_BIT];
    assign mon1_filter_disable = mon1_control_reg[vms_pkg::M1_FDIS_BIT];
    assign mon1_crossing_flag  = mon1_control_reg[vms_pkg::M1_FLAG_BIT];
    assign mon1_mode_sel       = mon1_control_reg[vms_pkg::M1_MODE_BIT];
    assign mon1_request_timing = mon1_control_reg[vms_pkg::M1_TIMING_BIT];
    assign mon1_filter_clk_sel =
        mon1_control_reg[vms_pkg::M1_FCLK_LO +: 2];

    // Monitor 0 reset takes its boot value from the option byte
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            boot_done        <= 1'b0;
            mon0_control_reg <= 8'h00;
        end else if (!boot_done) begin
            boot_done <= 1'b1;
            mon0_control_reg[vms_pkg::MON0_RST_BIT] <=
                (OPTION_BYTE[vms_pkg::OPT_MON0_RST_BIT] ==
                 vms_pkg::OPT_MON0_RST_ON);
        end else if (wr_en && addr_hit(paddr_i, vms_pkg::ADDR_MON0CTRL)) begin
            mon0_control_reg <= pwdata_i[7:0];
        end
    end

    // Plain software-written configuration registers
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            detector_control_reg <= 8'h00;
            monitor_enable_reg   <= 8'h00;
            mon1_threshold_reg   <= 8'h00;
        end else if (wr_en) begin
            unique case (paddr_i)
                vms_pkg::ADDR_DETCTRL:
                    detector_control_reg <= pwdata_i[7:0];
                vms_pkg::ADDR_MONEN:
                    monitor_enable_reg <= pwdata_i[7:0];
                vms_pkg::ADDR_THRESH:
                    mon1_threshold_reg <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // Clock mode register; the oscillator stop bit comes up set
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clock_mode_reg_one <= 8'h10;
        end else if (wr_en && addr_hit(paddr_i, vms_pkg::ADDR_CLKMODE)) begin
            clock_mode_reg_one <= pwdata_i[7:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_mask <= '0;
        end else if (wr_en && addr_hit(paddr_i, vms_pkg::ADDR_IRQMASK)) begin
            irq_mask <= pwdata_i[vms_pkg::IRQ_W-1:0];
        end
    end

    // Low-speed oscillator tick, runs only while its stop bit is clear
    assign lowspeed_osc_en_o = ~clock_mode_reg_one[vms_pkg::OSC_STOP_BIT];
    assign losc_tick = lowspeed_osc_en_o &&
        (losc_cnt == 8'(vms_pkg::LOSC_DIV - 1));
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            losc_cnt <= 8'h00;
        end else if (!lowspeed_osc_en_o || losc_tick) begin
            losc_cnt <= 8'h00;
        end else begin
            losc_cnt <= losc_cnt + 8'h01;
        end
    end

    // Sampling clock = oscillator / 1, 2, 4 or 8
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fdiv_cnt <= 3'h0;
        end else if (losc_tick) begin
            fdiv_cnt <= fdiv_cnt + 3'h1;
        end
    end

    always_comb begin
        unique case (vms_pkg::vms_fclk_e'(mon1_filter_clk_sel))
            vms_pkg::VMS_FDIV1: samp_tick = losc_tick;
            vms_pkg::VMS_FDIV2: samp_tick = losc_tick & fdiv_cnt[0];
            vms_pkg::VMS_FDIV4: samp_tick = losc_tick & (&fdiv_cnt[1:0]);
            vms_pkg::VMS_FDIV8: samp_tick = losc_tick & (&fdiv_cnt);
        endcase
    end

    // Digital filter: level changes after three equal samples
    always_comb begin
        next_filt_level = filt_level;
        if (&filt_sh) begin
            next_filt_level = 1'b1;
        end else if (~|filt_sh) begin
            next_filt_level = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_sh    <= '0;
            filt_level <= 1'b0;
        end else if (samp_tick) begin
            filt_sh    <= {filt_sh[vms_pkg::FILT_STAGES-2:0], det1_above_i};
            filt_level <= next_filt_level;
        end
    end

    assign det1_en_o = detector_control_reg[vms_pkg::DET1_EN_BIT];
    assign det0_en_o = detector_control_reg[vms_pkg::DET0_EN_BIT];
    assign mon12_en_o = monitor_enable_reg[vms_pkg::MON12_EN_BIT];
    assign mon1_threshold_o = mon1_threshold_reg[vms_pkg::THR_W-1:0];

    assign det_level = mon1_filter_disable ? det1_above_i
                                           : filt_level;

    // Previous detector level for edge detection
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            det_prev <= 1'b0;
        end else begin
            det_prev <= det_level;
        end
    end

    // Bypassed: timing bit 1 = falling, 0 = rising; filtered: both edges
    always_comb begin
        crossing = 1'b0;
        if (det1_en_o && mon12_en_o) begin
            if (!mon1_filter_disable) begin
                crossing = det_level ^ det_prev;
            end else if (mon1_request_timing) begin
                crossing = det_prev & ~det_level;
            end else begin
                crossing = ~det_prev & det_level;
            end
        end
    end

    // Crossing flag set wins over a software clear in the same cycle
    always_comb begin
        next_mon1_ctrl = mon1_control_reg;
        if (wr_en && addr_hit(paddr_i, vms_pkg::ADDR_MON1CTRL)) begin
            next_mon1_ctrl = pwdata_i[7:0];
        end
        if (crossing) begin
            next_mon1_ctrl[vms_pkg::M1_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mon1_control_reg <= vms_pkg::M1_CTRL_RST;
        end else begin
            mon1_control_reg <= next_mon1_ctrl;
        end
    end

    // Interrupt raised only by crossings while monitor 1 is enabled;
    // a new event wins over the read that clears the status
    always_comb begin
        next_irq_status = irq_status;
        if (rd_en && addr_hit(paddr_i, vms_pkg::ADDR_IRQSTAT)) begin
            next_irq_status = '0;
        end
        if (crossing && mon1_en && mon12_en_o && !mon1_mode_sel) begin
            next_irq_status[vms_pkg::IRQ_CROSS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // One-cycle reset pulse on a qualifying crossing
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mon1_reset_o <= 1'b0;
        end else begin
            mon1_reset_o <= crossing && mon1_en && mon12_en_o
                            && mon1_mode_sel;
        end
    end

    // Monitor 0 reset level while armed and detector 0 reports low
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mon0_reset_o <= 1'b0;
        end else begin
            mon0_reset_o <= mon0_control_reg[vms_pkg::MON0_RST_BIT]
                            && det0_en_o && det0_below_i;
        end
    end

    // Read data is loaded in the setup cycle and held until the next read
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                vms_pkg::ADDR_OPTION:
                    prdata_o <= {24'h0, OPTION_BYTE};
                vms_pkg::ADDR_DETCTRL:
                    prdata_o <= {24'h0, detector_control_reg};
                vms_pkg::ADDR_MON0CTRL:
                    prdata_o <= {24'h0, mon0_control_reg};
                vms_pkg::ADDR_MONEN:
                    prdata_o <= {24'h0, monitor_enable_reg};
                vms_pkg::ADDR_THRESH:
                    prdata_o <= {24'h0, mon1_threshold_reg};
                vms_pkg::ADDR_MON1CTRL:
                    prdata_o <= {24'h0, mon1_control_reg};
                vms_pkg::ADDR_CLKMODE:
                    prdata_o <= {24'h0, clock_mode_reg_one};
                vms_pkg::ADDR_IRQSTAT:
                    prdata_o <= {31'h0, irq_status};
                vms_pkg::ADDR_IRQMASK:
                    prdata_o <= {31'h0, irq_mask};
                default:
                    prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // vms_voltage_monitor

// ---- verilog/vms_pkg.sv ----
package vms_pkg;
    // APB byte addresses of the block registers
    localparam logic [7:0] ADDR_OPTION   = 8'h00;
    localparam logic [7:0] ADDR_DETCTRL  = 8'h04;
    localparam logic [7:0] ADDR_MON0CTRL = 8'h08;
    localparam logic [7:0] ADDR_MONEN    = 8'h0C;
    localparam logic [7:0] ADDR_THRESH   = 8'h10;
    localparam logic [7:0] ADDR_MON1CTRL = 8'h14;
    localparam logic [7:0] ADDR_CLKMODE  = 8'h18;
    localparam logic [7:0] ADDR_IRQSTAT  = 8'h1C;
    localparam logic [7:0] ADDR_IRQMASK  = 8'h20;

    // Non-volatile option byte
    localparam logic [15:0] OPTION_BYTE_ADDR  = 16'hFFFF;
    localparam logic [7:0]  OPTION_BYTE_DEF   = 8'h9F;
    localparam int          OPT_MON0_RST_BIT  = 5;
    // Option bit value that leaves monitor 0 reset armed at boot
    localparam logic        OPT_MON0_RST_ON   = 1'b0;

    // Detector control, monitor 0 control, monitor enable, clock mode and threshold fields
    localparam int DET0_EN_BIT = 5;
    localparam int DET1_EN_BIT = 6;
    localparam int MON0_RST_BIT = 0;
    localparam int MON12_EN_BIT = 7;
    localparam int OSC_STOP_BIT = 4;
    localparam int THR_W = 4;

    // Monitor 1 control fields
    localparam int M1_EN_BIT     = 0;
    localparam int M1_FDIS_BIT   = 1;
    localparam int M1_FLAG_BIT   = 2;
    localparam int M1_FCLK_LO    = 4;
    localparam int M1_MODE_BIT   = 6;
    localparam int M1_TIMING_BIT = 7;
    localparam logic [7:0] M1_CTRL_RST = 8'h0A;

    // Interrupt status bits
    localparam int IRQ_CROSS_BIT = 0;
    localparam int IRQ_W         = 1;

    // Filter sampling clock from the 125 kHz oscillator
    localparam int  CLK_HZ      = 10_000_000;
    localparam int  LOSC_HZ     = 125_000;
    localparam int  LOSC_DIV    = CLK_HZ / LOSC_HZ;
    localparam int  FILT_STAGES = 3;

    typedef enum logic [1:0] {
        VMS_FDIV1, VMS_FDIV2, VMS_FDIV4, VMS_FDIV8
    } vms_fclk_e;
endpackage

// ---- tb/vms_voltage_monitor_monitor.sv ----
`timescale 1ns/1ps
module vms_voltage_monitor_monitor (
    input wire logic       core_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic       det0_below_i,
    input wire logic       mon0_reset_o,
    input wire logic       mon1_reset_o,
    input wire logic       mon12_en_o,
    input wire logic [3:0] mon1_threshold_o,
    input wire logic       det0_en_o,
    input wire logic       det1_en_o,
    input wire logic       lowspeed_osc_en_o,
    input wire logic       irq_o
);
    logic wr;
    assign wr = psel_i && penable_i && pwrite_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_mon0; mon0_reset_o |-> $past(det0_en_o && det0_below_i);
    endproperty
    a_mon0: assert property (p_mon0)
        else $error("monitor 0 reset without armed detector");
    property p_m1pulse; mon1_reset_o |=> !mon1_reset_o; endproperty
    a_m1pulse: assert property (p_m1pulse)
        else $error("monitor 1 reset pulse too long");
    property p_m1en; mon1_reset_o |-> $past(mon12_en_o && det1_en_o);
    endproperty
    a_m1en: assert property (p_m1en)
        else $error("monitor 1 reset while disabled");
    property p_osc; $changed(lowspeed_osc_en_o)
        |-> $past(wr && paddr_i == vms_pkg::ADDR_CLKMODE); endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator enable changed without write");
    property p_thr; $changed(mon1_threshold_o)
        |-> $past(wr && paddr_i == vms_pkg::ADDR_THRESH); endproperty
    a_thr: assert property (p_thr)
        else $error("threshold changed without write");
    property p_det; $changed({det0_en_o, det1_en_o})
        |-> $past(wr && paddr_i == vms_pkg::ADDR_DETCTRL); endproperty
    a_det: assert property (p_det)
        else $error("detector enable changed without write");
    property p_shared; $changed(mon12_en_o)
        |-> $past(wr && paddr_i == vms_pkg::ADDR_MONEN); endproperty
    a_shared: assert property (p_shared)
        else $error("shared enable changed without write");
    property p_irqfall; $fell(irq_o) |-> $past(psel_i && penable_i);
    endproperty
    a_irqfall: assert property (p_irqfall)
        else $error("interrupt dropped without bus access");
endmodule // vms_voltage_monitor_monitor

bind vms_voltage_monitor vms_voltage_monitor_monitor u_mon (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .det0_below_i(det0_below_i), .mon0_reset_o(mon0_reset_o),
    .mon1_reset_o(mon1_reset_o), .mon12_en_o(mon12_en_o),
    .mon1_threshold_o(mon1_threshold_o), .det0_en_o(det0_en_o),
    .det1_en_o(det1_en_o), .lowspeed_osc_en_o(lowspeed_osc_en_o),
    .irq_o(irq_o));

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] M1C = vms_pkg::ADDR_MON1CTRL;
    localparam logic [7:0] IST = vms_pkg::ADDR_IRQSTAT;
    localparam int         P   = vms_pkg::LOSC_DIV;
    logic        core_clk_i   = 1'b0;
    logic        sys_rst_i    = 1'b1;
    logic        psel_i       = 1'b0;
    logic        penable_i    = 1'b0;
    logic        pwrite_i     = 1'b0;
    logic [7:0]  paddr_i      = 8'h00;
    logic [31:0] pwdata_i     = 32'h0;
    logic        det0_below_i = 1'b1;
    logic        det1_above_i = 1'b1;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, err, mon0_reset_o, mon1_reset_o, hit;
    logic        mon12_en_o, det0_en_o, det1_en_o, lowspeed_osc_en_o, irq_o;
    logic [3:0]  mon1_threshold_o, th;
    int          err_count = 0, num_checks = 0, n, d;

    vms_voltage_monitor u_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .det0_below_i(det0_below_i),
        .det1_above_i(det1_above_i), .mon0_reset_o(mon0_reset_o),
        .mon1_reset_o(mon1_reset_o), .mon12_en_o(mon12_en_o),
        .mon1_threshold_o(mon1_threshold_o), .det0_en_o(det0_en_o),
        .det1_en_o(det1_en_o), .lowspeed_osc_en_o(lowspeed_osc_en_o),
        .irq_o(irq_o));

    always #50 core_clk_i = ~core_clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] dat);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= dat;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq_o !== 1'b1 && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask
    // Moves the comparator input and watches for a reset pulse
    task automatic edge_pulse(input logic v);
        det1_above_i <= v;
        hit = 1'b0;
        // Sample on the falling edge, where the one-cycle pulse is settled
        repeat (5) begin
            @(negedge core_clk_i);
            if (mon1_reset_o === 1'b1) hit = 1'b1;
        end
        @(posedge core_clk_i);
    endtask
    task automatic complete_run;
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        cyc(20000);
        err_count++;
        complete_run();
    end

    initial begin
        void'($urandom(56));
        cyc(16);
        sys_rst_i <= 1'b0;
        cyc(2);
        rdchk(vms_pkg::ADDR_OPTION, 32'h9F);
        apb(1'b1, vms_pkg::ADDR_OPTION, 32'h00);
        rdchk(vms_pkg::ADDR_OPTION, 32'h9F);
        rdchk(M1C, 32'h0A);
        rdchk(vms_pkg::ADDR_CLKMODE, 32'h10);
        rdchk(8'h40, 32'h0);
        check(32'(err), 32'h1);
        check(32'(pready_o), 32'h1);
        check(32'(mon0_reset_o), 32'h0);
        apb(1'b1, vms_pkg::ADDR_DETCTRL, 32'h20);
        cyc(4);
        check(32'(mon0_reset_o), 32'h1);
        apb(1'b1, vms_pkg::ADDR_MON0CTRL, 32'h0);
        cyc(2);
        check(32'(mon0_reset_o), 32'h0);
        apb(1'b1, vms_pkg::ADDR_MON0CTRL, 32'h1);
        cyc(2);
        check(32'(mon0_reset_o), 32'h1);
        det0_below_i <= 1'b0;
        apb(1'b1, vms_pkg::ADDR_MONEN, 32'h80);
        repeat (3) begin
            th = 4'($urandom);
            apb(1'b1, vms_pkg::ADDR_THRESH, 32'(th));
            cyc(1);
            check(32'(mon1_threshold_o), 32'(th));
        end
        apb(1'b1, vms_pkg::ADDR_DETCTRL, 32'h60);
        apb(1'b1, vms_pkg::ADDR_IRQMASK, 32'h1);
        cyc(8);
        check(32'({mon12_en_o, det1_en_o, det0_en_o}), 32'h7);
        apb(1'b1, M1C, 32'h82);
        edge_pulse(1'b0);
        rdchk(M1C, 32'h86);
        check(32'(irq_o), 32'h0);
        apb(1'b1, M1C, 32'h82);
        edge_pulse(1'b1);
        apb(1'b1, M1C, 32'h83);
        cyc(4);
        rdchk(IST, 32'h0);
        edge_pulse(1'b0);
        check(32'(irq_o), 32'h1);
        rdchk(IST, 32'h1);
        cyc(1);
        check(32'(irq_o), 32'h0);
        edge_pulse(1'b1);
        check(32'(irq_o), 32'h0);
        apb(1'b1, M1C, 32'h02);
        apb(1'b1, vms_pkg::ADDR_IRQMASK, 32'h0);
        apb(1'b1, M1C, 32'h03);
        edge_pulse(1'b0);
        edge_pulse(1'b1);
        check(32'(irq_o), 32'h0);
        apb(1'b1, vms_pkg::ADDR_IRQMASK, 32'h1);
        cyc(1);
        check(32'(irq_o), 32'h1);
        rdchk(IST, 32'h1);
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, M1C, 32'({t[0], 7'h42}));
            edge_pulse(t[0]);
            apb(1'b1, M1C, 32'({t[0], 7'h43}));
            edge_pulse(!t[0]);
            check(32'(hit), 32'h1);
        end
        apb(1'b1, vms_pkg::ADDR_CLKMODE, 32'h00);
        cyc(1);
        check(32'(lowspeed_osc_en_o), 32'h1);
        for (int f = 0; f < 4; f++) begin
            d = P << f;
            apb(1'b1, M1C, 32'h80 + 32'(f * 16));
            cyc(3 * d + $urandom_range(0, 9));
            apb(1'b1, M1C, 32'h81 + 32'(f * 16));
            apb(1'b0, IST, 32'h0);
            cyc(1);
            det1_above_i <= ~det1_above_i;
            wait_irq(4 * d + 20);
            check(32'(n > d && n < 4 * d + 20), 32'h1);
        end
        complete_run();
    end
endmodule // tb
